// ==== hdl/dca_pkg.sv ====
package dca_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DATA_W = 24;
    localparam int ACC_W = 56;
    localparam int XY_W = 48;
    localparam int PTR_W = 16;
    localparam int NUM_DREG = 4;
    localparam int NUM_ACC = 4;
    localparam int NUM_PTR = 4;
    localparam int SHAMT_W = 5;
    localparam int ADDR_W = 16;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [23:0] DREG_RST = 24'h000000;
    localparam logic [55:0] ACC_RST = 56'h00000000000000;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [15:0] PC_RST = 16'h0000;

    // ------------------------------------------------------------
    // operations
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        DCA_OP_NOP,
        DCA_OP_ABS,
        DCA_OP_RETURN,
        DCA_OP_INTERRUPT_RETURN,
        DCA_OP_SHIFT_LEFT_LOGICAL,
        DCA_OP_SHIFT_RIGHT_ARITH,
        DCA_OP_SHIFT_RIGHT_LOGICAL,
        DCA_OP_SLEEP,
        DCA_OP_STORE,
        DCA_OP_SUB,
        DCA_OP_DIFF_TIMES_TO_ACC,
        DCA_OP_DIFF_TIMES_ACC_ADD,
        DCA_OP_DIFF_TIMES_NEGATED_TO_ACC,
        DCA_OP_DIFF_TIMES_ACC_DEDUCT,
        DCA_OP_HALVING_DIFFERENCE,
        DCA_OP_POINTER_STEP_DECREASE,
        DCA_OP_SWAP,
        DCA_OP_XOR
    } dca_op_t;

    // source / destination selectors
    typedef enum logic [1:0] {
        DCA_LOC_DREG,
        DCA_LOC_ACC,
        DCA_LOC_IMM,
        DCA_LOC_MEM
    } dca_loc_t;
endpackage

// ==== hdl/dca_core.sv ====
`timescale 1ns/1ps
// Function
// - absolute value writes operand magnitude, data register or accumulator
// - subroutine return jumps back to saved return address
// - interrupt return ends service, restores interrupted flow context
// - logical left shift fills vacated low bits with zeros
// - arithmetic right shift keeps the sign
// - logical right shift fills vacated high bits with zeros
// - sleep halts execution until an interrupt arrives
// - store copies immediate, register or accumulator to register, acc, memory
// - subtract two data registers or accumulators into register or acc
// - (a-b)*c of XY registers overwrites an accumulator
// - (a-b)*c of XY registers added to accumulator
// - (a-b)*c of XY registers negated into accumulator
// - (a-b)*c of XY registers subtracted from accumulator
// - difference shifted right one bit into register or accumulator
// - pointer decreased by its step register
// - swap two data registers only when condition holds
// - bitwise xor of two registers or register and immediate
// - four 56-bit accumulators
// - four 24-bit data registers
// - XY operands come from one 48-bit combined memory word
module dca_core #(
    parameter int NUM_DREG = dca_pkg::NUM_DREG,
    parameter int NUM_ACC = dca_pkg::NUM_ACC,
    parameter int NUM_PTR = dca_pkg::NUM_PTR
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // instruction issue
    input wire logic instr_valid,
    output logic instr_ready,
    input wire dca_pkg::dca_op_t op,
    input wire dca_pkg::dca_loc_t src_loc,
    input wire dca_pkg::dca_loc_t dst_loc,
    input wire logic [1:0] sel_a,
    input wire logic [1:0] sel_b,
    input wire logic [1:0] sel_c,
    input wire logic [1:0] sel_d,
    input wire logic [dca_pkg::DATA_W-1:0] imm,
    input wire logic [dca_pkg::SHAMT_W-1:0] shamt,
    input wire logic cond,
    // program flow
    input wire logic [dca_pkg::ADDR_W-1:0] ret_addr,
    input wire logic [dca_pkg::ADDR_W-1:0] int_ret_addr,
    input wire logic [7:0] int_saved_status,
    input wire logic irq,
    output logic pc_load,
    output logic [dca_pkg::ADDR_W-1:0] pc_target_q,
    output logic [7:0] status_q,
    output logic in_isr_q,
    output logic sleeping_q,
    // xy memory
    input wire logic [dca_pkg::XY_W-1:0] xy_word,
    output logic mem_we_q,
    output logic [dca_pkg::ADDR_W-1:0] mem_addr_q,
    output logic [dca_pkg::DATA_W-1:0] mem_wdata_q,
    // pointers and steps
    input wire logic [NUM_PTR*dca_pkg::PTR_W-1:0] step_flat,
    output logic [NUM_PTR*dca_pkg::PTR_W-1:0] ptr_flat,
    // register file view
    output logic [NUM_DREG*dca_pkg::DATA_W-1:0] dreg_flat,
    output logic [NUM_ACC*dca_pkg::ACC_W-1:0] acc_flat
);
    localparam int DW = dca_pkg::DATA_W;
    localparam int AW = dca_pkg::ACC_W;
    localparam int PW = dca_pkg::PTR_W;
    localparam int XY_HI = dca_pkg::XY_W - 1;

    // selectors are 2 bits wide, so only four of each can be reached
    if (NUM_DREG != 4 || NUM_ACC != 4 || NUM_PTR != 4) begin : g_cfg_check
        $error("register counts must be 4 to match 2-bit selectors");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [AW-1:0] sext(input logic [DW-1:0] v);
        sext = {{(AW-DW){v[DW-1]}}, v};
    endfunction

    function automatic logic [AW-1:0] mag(input logic [AW-1:0] v);
        mag = v[AW-1] ? AW'(-v) : v;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [DW-1:0] dreg_q [NUM_DREG];
    logic [DW-1:0] dreg_d [NUM_DREG];
    logic [AW-1:0] acc_q [NUM_ACC];
    logic [AW-1:0] acc_d [NUM_ACC];
    logic [PW-1:0] ptr_q [NUM_PTR];
    logic [PW-1:0] ptr_d [NUM_PTR];
    logic [dca_pkg::ADDR_W-1:0] pc_target_d;
    logic [7:0] status_d;
    logic in_isr_d;
    logic sleeping_d;
    logic mem_we_d;
    logic [dca_pkg::ADDR_W-1:0] mem_addr_d;
    logic [DW-1:0] mem_wdata_d;
    logic pc_load_q;
    logic pc_load_d;

    // ------------------------------------------------------------
    // operand fetch
    // ------------------------------------------------------------
    logic [DW-1:0] xa, xb, xc;
    logic [DW-1:0] da, db;
    logic [AW-1:0] aa, ab;
    logic signed [DW:0] xdiff;
    logic signed [2*DW+1:0] xprod;
    logic [AW-1:0] prod_ext;
    logic take;

    always_comb begin
        // xy word holds x in high half, y in low half
        xa = sel_a[1] ? xy_word[XY_HI:DW] : dreg_q[sel_a];
        xb = sel_b[1] ? xy_word[DW-1:0] : dreg_q[sel_b];
        xc = dreg_q[sel_c];
        da = dreg_q[sel_a];
        db = (src_loc == dca_pkg::DCA_LOC_IMM) ? imm : dreg_q[sel_b];
        aa = acc_q[sel_a];
        ab = acc_q[sel_b];
        xdiff = $signed({xa[DW-1], xa}) - $signed({xb[DW-1], xb});
        xprod = xdiff * $signed({xc[DW-1], xc});
        prod_ext = AW'(xprod);
    end

    assign take = instr_valid && !sleeping_q;
    assign instr_ready = !sleeping_q;

    // ------------------------------------------------------------
    // execute
    // ------------------------------------------------------------
    always_comb begin
        logic [AW-1:0] r_acc;
        logic [DW-1:0] r_dat;
        logic wr;
        r_acc = '0;
        r_dat = '0;
        wr = 1'b0;
        for (int i = 0; i < NUM_DREG; i++) dreg_d[i] = dreg_q[i];
        for (int i = 0; i < NUM_ACC; i++) acc_d[i] = acc_q[i];
        for (int i = 0; i < NUM_PTR; i++) ptr_d[i] = ptr_q[i];
        pc_target_d = pc_target_q;
        pc_load_d = 1'b0;
        status_d = status_q;
        in_isr_d = in_isr_q;
        sleeping_d = sleeping_q;
        mem_we_d = 1'b0;
        mem_addr_d = mem_addr_q;
        mem_wdata_d = mem_wdata_q;
        if (sleeping_q && irq) begin
            sleeping_d = 1'b0;
            // waking interrupt starts service until interrupt return
            in_isr_d = 1'b1;
        end
        if (take) begin
            case (op)
                dca_pkg::DCA_OP_ABS: begin
                    wr = 1'b1;
                    r_acc = (src_loc == dca_pkg::DCA_LOC_ACC) ?
                        mag(aa) : mag(sext(da));
                    r_dat = r_acc[DW-1:0];
                end
                dca_pkg::DCA_OP_RETURN: begin
                    pc_target_d = ret_addr;
                    pc_load_d = 1'b1;
                end
                dca_pkg::DCA_OP_INTERRUPT_RETURN: begin
                    pc_target_d = int_ret_addr;
                    status_d = int_saved_status;
                    in_isr_d = 1'b0;
                    pc_load_d = 1'b1;
                end
                dca_pkg::DCA_OP_SHIFT_LEFT_LOGICAL: begin
                    wr = 1'b1;
                    r_dat = da << shamt;
                    r_acc = sext(r_dat);
                end
                dca_pkg::DCA_OP_SHIFT_RIGHT_ARITH: begin
                    wr = 1'b1;
                    r_dat = DW'($signed(da) >>> shamt);
                    r_acc = sext(r_dat);
                end
                dca_pkg::DCA_OP_SHIFT_RIGHT_LOGICAL: begin
                    wr = 1'b1;
                    r_dat = da >> shamt;
                    r_acc = sext(r_dat);
                end
                dca_pkg::DCA_OP_SLEEP: begin
                    sleeping_d = !irq;
                end
                dca_pkg::DCA_OP_STORE: begin
                    wr = 1'b1;
                    case (src_loc)
                        dca_pkg::DCA_LOC_IMM: r_acc = sext(imm);
                        dca_pkg::DCA_LOC_ACC: r_acc = aa;
                        default: r_acc = sext(da);
                    endcase
                    r_dat = r_acc[DW-1:0];
                    if (dst_loc == dca_pkg::DCA_LOC_MEM) begin
                        wr = 1'b0;
                        mem_we_d = 1'b1;
                        mem_addr_d = ptr_q[sel_d];
                        mem_wdata_d = r_dat;
                    end
                end
                dca_pkg::DCA_OP_SUB: begin
                    wr = 1'b1;
                    r_acc = (src_loc == dca_pkg::DCA_LOC_ACC) ?
                        AW'(aa - ab) : AW'(sext(da) - sext(db));
                    r_dat = r_acc[DW-1:0];
                end
                dca_pkg::DCA_OP_HALVING_DIFFERENCE: begin
                    wr = 1'b1;
                    r_acc = (src_loc == dca_pkg::DCA_LOC_ACC) ?
                        AW'(aa - ab) : AW'(sext(da) - sext(db));
                    r_acc = AW'($signed(r_acc) >>> 1);
                    r_dat = r_acc[DW-1:0];
                end
                dca_pkg::DCA_OP_DIFF_TIMES_TO_ACC: begin
                    acc_d[sel_d] = prod_ext;
                end
                dca_pkg::DCA_OP_DIFF_TIMES_ACC_ADD: begin
                    acc_d[sel_d] = AW'(acc_q[sel_d] + prod_ext);
                end
                dca_pkg::DCA_OP_DIFF_TIMES_NEGATED_TO_ACC: begin
                    acc_d[sel_d] = AW'(-prod_ext);
                end
                dca_pkg::DCA_OP_DIFF_TIMES_ACC_DEDUCT: begin
                    acc_d[sel_d] = AW'(acc_q[sel_d] - prod_ext);
                end
                dca_pkg::DCA_OP_POINTER_STEP_DECREASE: begin
                    ptr_d[sel_d] = PW'(ptr_q[sel_d] -
                        step_flat[sel_d*PW +: PW]);
                end
                dca_pkg::DCA_OP_SWAP: begin
                    if (cond) begin
                        dreg_d[sel_a] = dreg_q[sel_b];
                        dreg_d[sel_b] = dreg_q[sel_a];
                    end
                end
                dca_pkg::DCA_OP_XOR: begin
                    dreg_d[sel_d] = da ^ db;
                end
                default: begin
                end
            endcase
            if (wr) begin
                if (dst_loc == dca_pkg::DCA_LOC_ACC) begin
                    acc_d[sel_d] = r_acc;
                end else begin
                    dreg_d[sel_d] = r_dat;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_DREG; i++) dreg_q[i] <= dca_pkg::DREG_RST;
            for (int i = 0; i < NUM_ACC; i++) acc_q[i] <= dca_pkg::ACC_RST;
            for (int i = 0; i < NUM_PTR; i++) ptr_q[i] <= dca_pkg::PTR_RST;
            pc_target_q <= dca_pkg::PC_RST;
            pc_load_q <= 1'b0;
            status_q <= 8'h00;
            in_isr_q <= 1'b0;
            sleeping_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= dca_pkg::PC_RST;
            mem_wdata_q <= dca_pkg::DREG_RST;
        end else begin
            for (int i = 0; i < NUM_DREG; i++) dreg_q[i] <= dreg_d[i];
            for (int i = 0; i < NUM_ACC; i++) acc_q[i] <= acc_d[i];
            for (int i = 0; i < NUM_PTR; i++) ptr_q[i] <= ptr_d[i];
            pc_target_q <= pc_target_d;
            pc_load_q <= pc_load_d;
            status_q <= status_d;
            in_isr_q <= in_isr_d;
            sleeping_q <= sleeping_d;
            mem_we_q <= mem_we_d;
            mem_addr_q <= mem_addr_d;
            mem_wdata_q <= mem_wdata_d;
        end
    end

    assign pc_load = pc_load_q;

    always_comb begin
        for (int i = 0; i < NUM_DREG; i++) dreg_flat[i*DW +: DW] = dreg_q[i];
        for (int i = 0; i < NUM_ACC; i++) acc_flat[i*AW +: AW] = acc_q[i];
        for (int i = 0; i < NUM_PTR; i++) ptr_flat[i*PW +: PW] = ptr_q[i];
    end
endmodule

// ==== verification/dca_core_monitor.sv ====
`timescale 1ns/1ps
module dca_core_monitor #(
    parameter int NUM_DREG = dca_pkg::NUM_DREG,
    parameter int NUM_ACC = dca_pkg::NUM_ACC,
    parameter int NUM_PTR = dca_pkg::NUM_PTR
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // issue
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire dca_pkg::dca_op_t op,
    input wire dca_pkg::dca_loc_t dst_loc,
    input wire logic cond,
    // program flow
    input wire logic [dca_pkg::ADDR_W-1:0] ret_addr,
    input wire logic [dca_pkg::ADDR_W-1:0] int_ret_addr,
    input wire logic [7:0] int_saved_status,
    input wire logic irq,
    input wire logic pc_load,
    input wire logic [dca_pkg::ADDR_W-1:0] pc_target_q,
    input wire logic [7:0] status_q,
    input wire logic in_isr_q,
    input wire logic sleeping_q,
    // results
    input wire logic mem_we_q,
    input wire logic [NUM_DREG*dca_pkg::DATA_W-1:0] dreg_flat
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic take;
    logic flow;
    logic wr_mem;
    assign take = instr_valid && instr_ready;
    assign flow = take && (op == dca_pkg::DCA_OP_RETURN ||
        op == dca_pkg::DCA_OP_INTERRUPT_RETURN);
    assign wr_mem = take && op == dca_pkg::DCA_OP_STORE &&
        dst_loc == dca_pkg::DCA_LOC_MEM;
    sequence nap;
        take && op == dca_pkg::DCA_OP_SLEEP && !irq;
    endsequence
    sequence rouse;
        sleeping_q && irq;
    endsequence
    ready_sleep_a: assert property (instr_ready == !sleeping_q)
        else $error("ready while asleep");
    sleep_enter_a: assert property (nap |=> sleeping_q
        ##1 ($past(irq) || sleeping_q)) else $error("sleep not held");
    wake_up_a: assert property (rouse |=> !sleeping_q && instr_ready
        && in_isr_q) else $error("no wake on interrupt");
    ret_jump_a: assert property (take && op == dca_pkg::DCA_OP_RETURN
        |=> pc_load && pc_target_q == $past(ret_addr))
        else $error("bad return target");
    iret_restore_a: assert property (take &&
        op == dca_pkg::DCA_OP_INTERRUPT_RETURN |=> pc_load && !in_isr_q &&
        pc_target_q == $past(int_ret_addr) &&
        status_q == $past(int_saved_status)) else $error("bad iret");
    pc_cause_a: assert property (pc_load |-> $past(flow))
        else $error("stray flow change");
    mem_cause_a: assert property (mem_we_q |-> $past(wr_mem))
        else $error("stray memory write");
    swap_hold_a: assert property (take && !cond &&
        op == dca_pkg::DCA_OP_SWAP |=> $stable(dreg_flat))
        else $error("swap without condition");
endmodule

bind dca_core dca_core_monitor #(
    .NUM_DREG(NUM_DREG), .NUM_ACC(NUM_ACC), .NUM_PTR(NUM_PTR)
) u_mon (.clk, .rst, .instr_valid, .instr_ready, .op, .dst_loc, .cond,
    .ret_addr, .int_ret_addr, .int_saved_status, .irq, .pc_load,
    .pc_target_q, .status_q, .in_isr_q, .sleeping_q, .mem_we_q, .dreg_flat);

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    typedef struct {int due; int k; int i; logic [55:0] e;} dca_note_t;
    // stimulus
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    logic cond = 1'b0;
    logic irq = 1'b0;
    dca_pkg::dca_op_t op = dca_pkg::DCA_OP_NOP;
    dca_pkg::dca_loc_t src_loc = dca_pkg::DCA_LOC_DREG;
    dca_pkg::dca_loc_t dst_loc = dca_pkg::DCA_LOC_DREG;
    logic [1:0] sel_a = 2'h0, sel_b = 2'h0, sel_c = 2'h2, sel_d = 2'h0;
    logic [4:0] shamt = 5'h00;
    logic [7:0] int_saved_status = 8'h00;
    logic [15:0] ret_addr = 16'h0000, int_ret_addr = 16'h0000;
    logic [23:0] imm = 24'h000000;
    logic [47:0] xy_word = 48'h000000000000;
    logic [63:0] step_flat = 64'h0000000000000000;
    // observed
    logic instr_ready, pc_load, in_isr_q, sleeping_q, mem_we_q;
    logic [7:0] status_q;
    logic [15:0] pc_target_q, mem_addr_q;
    logic [23:0] mem_wdata_q;
    logic [63:0] ptr_flat;
    logic [95:0] dreg_flat;
    logic [223:0] acc_flat;
    // scoreboard and mirror
    dca_note_t q[$];
    dca_note_t n;
    logic [55:0] s, p, got;
    logic [63:0] w;
    logic [31:0] v;
    logic [23:0] md[4];
    logic [55:0] ma[4];
    logic [15:0] mp[4] = '{default: 16'h0000};
    int ncnt = 0;
    int failures = 0;
    int checks = 0;

    dca_core dut (.clk, .rst, .instr_valid, .instr_ready, .op, .src_loc,
        .dst_loc, .sel_a, .sel_b, .sel_c, .sel_d, .imm, .shamt, .cond,
        .ret_addr, .int_ret_addr, .int_saved_status, .irq, .pc_load,
        .pc_target_q, .status_q, .in_isr_q, .sleeping_q, .xy_word,
        .mem_we_q, .mem_addr_q, .mem_wdata_q, .step_flat, .ptr_flat,
        .dreg_flat, .acc_flat);

    always #12.5 clk = ~clk;

    function automatic logic [55:0] sx(input logic [23:0] x);
        return {{32{x[23]}}, x};
    endfunction
    task automatic check(input logic [55:0] seen, input logic [55:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic note(input int k, input int i, input logic [55:0] e,
        input int off = 2);
        q.push_back('{ncnt + off, k, i, e});
    endtask
    // op and location codes are enum positions; v feeds imm, shamt, cond
    task automatic go(input int o, input int sl, input int dl, input int a,
        input int b, input int d);
        @(posedge clk);
        instr_valid <= 1'b1;
        op <= dca_pkg::dca_op_t'(o);
        src_loc <= dca_pkg::dca_loc_t'(sl);
        dst_loc <= dca_pkg::dca_loc_t'(dl);
        sel_a <= a[1:0];
        sel_b <= b[1:0];
        sel_d <= d[1:0];
        imm <= v[23:0];
        shamt <= v[4:0];
        cond <= v[0];
    endtask
    task automatic fin(input string t);
        $display("test %s done", t);
    endtask
    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // result watcher: kind picks which outputs hold the result
    always @(negedge clk) begin
        ncnt++;
        while (q.size() > 0 && q[0].due == ncnt) begin
            n = q.pop_front();
            case (n.k)
                0: got = {32'h00000000, dreg_flat[n.i*24 +: 24]};
                1: got = acc_flat[n.i*56 +: 56];
                2: got = {40'h0000000000, ptr_flat[n.i*16 +: 16]};
                3: got = {31'h00000000, pc_load, pc_target_q, status_q};
                4: got = {15'h0000, mem_we_q, mem_addr_q, mem_wdata_q};
                default: got = {53'h0, in_isr_q, sleeping_q, instr_ready};
            endcase
            check(got, n.e);
        end
    end

    // tests take about 70 cycles; generous margin
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        results();
    end

    initial begin
        void'($urandom(32'hE0DA1314));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            go(8, 2, 0, 0, 0, i);
            md[i] = v[23:0];
            note(0, i, md[i]);
            v = $urandom;
            go(8, 2, 1, 0, 0, i);
            ma[i] = sx(v[23:0]);
            note(1, i, ma[i]);
        end
        fin("store");
        w = {$urandom, $urandom};
        step_flat <= w;
        for (int i = 0; i < 8; i++) begin
            go(15, 0, 0, 0, 0, i % 4);
            mp[i%4] = mp[i%4] - w[(i%4)*16 +: 16];
            note(2, i % 4, mp[i%4]);
        end
        go(8, 0, 3, 2, 0, 1);
        note(4, 0, {1'b1, mp[1], md[2]});
        fin("pointer");
        for (int i = 0; i < 6; i++) begin
            v = $urandom % 24;
            go(4 + i % 3, 0, 0, i % 4, 0, i % 4);
            case (i % 3)
                0: md[i%4] = md[i%4] << v[4:0];
                1: md[i%4] = $signed(md[i%4]) >>> v[4:0];
                default: md[i%4] = md[i%4] >> v[4:0];
            endcase
            note(0, i % 4, md[i%4]);
        end
        fin("shift");
        v = $urandom | 32'h00800000;
        go(8, 2, 0, 0, 0, 0);
        go(1, 0, 0, 0, 0, 0);
        md[0] = -v[23:0];
        note(0, 0, md[0]);
        go(1, 1, 1, 1, 0, 1);
        if (ma[1][55]) ma[1] = -ma[1];
        note(1, 1, ma[1]);
        go(9, 0, 1, 0, 1, 2);
        ma[2] = sx(md[0]) - sx(md[1]);
        note(1, 2, ma[2]);
        go(9, 1, 1, 2, 3, 0);
        ma[0] = ma[2] - ma[3];
        note(1, 0, ma[0]);
        go(14, 0, 0, 0, 1, 2);
        s = sx(md[0]) - sx(md[1]);
        md[2] = s[24:1];
        note(0, 2, md[2]);
        go(14, 1, 1, 0, 1, 3);
        s = ma[0] - ma[1];
        ma[3] = {s[55], s[55:1]};
        note(1, 3, ma[3]);
        fin("arith");
        for (int k = 0; k < 4; k++) begin
            w = {$urandom, $urandom};
            go(10 + k, 0, 1, k > 1 ? 2 : 0, k == 3 ? 3 : 1, k);
            xy_word <= w[47:0];
            sel_c <= 2'(k + 2);
            s = sx(k > 1 ? w[47:24] : md[0]) - sx(k == 3 ? w[23:0] : md[1]);
            p = s * sx(md[(k + 2) % 4]);
            ma[k] = k == 0 ? p : k == 1 ? ma[k] + p : k == 2 ? -p : ma[k] - p;
            note(1, k, ma[k]);
        end
        fin("diff");
        v = 0;
        go(16, 0, 0, 0, 1, 0);
        note(0, 0, md[0]);
        v = 1;
        go(16, 0, 0, 0, 1, 0);
        {md[0], md[1]} = {md[1], md[0]};
        note(0, 1, md[1]);
        v = $urandom;
        go(17, 2, 0, 1, 0, 3);
        md[3] = md[1] ^ v[23:0];
        note(0, 3, md[3]);
        go(17, 0, 0, 2, 3, 0);
        md[0] = md[2] ^ md[3];
        note(0, 0, md[0]);
        go(8, 1, 0, 3, 0, 2);
        md[2] = ma[3][23:0];
        note(0, 2, md[2]);
        fin("logic");
        w = {$urandom, $urandom};
        ret_addr <= w[15:0];
        int_ret_addr <= w[31:16];
        int_saved_status <= w[39:32];
        go(2, 0, 0, 0, 0, 0);
        note(3, 0, {1'b1, w[15:0], 8'h00});
        go(3, 0, 0, 0, 0, 0);
        note(3, 0, {1'b1, w[31:16], w[39:32]});
        go(7, 0, 0, 0, 0, 0);
        note(5, 0, 56'h2);
        v = $urandom;
        go(8, 2, 0, 0, 0, 0);
        note(5, 0, 56'h2);
        @(posedge clk);
        irq <= 1'b1;
        note(5, 0, 56'h5);
        note(0, 0, v[23:0], 3);
        @(posedge clk);
        irq <= 1'b0;
        go(3, 0, 0, 0, 0, 0);
        note(5, 0, 56'h1);
        note(3, 0, {1'b1, w[31:16], w[39:32]});
        @(posedge clk);
        instr_valid <= 1'b0;
        fin("flow");
        repeat (4) @(posedge clk);
        results();
    end
endmodule
